// File: sfic_pkg.sv
// Summary of operation
// - Status flags register at address 0x0a
// - Software writes never touch power-down, timeout
// - Timeout flag: clear on power-up/clear/halt
// - Power-down flag: set halt, clear power-up/clear
// - Carry from add, no-borrow, rotate
// - Half carry from low nibble
// - Zero flag when result is zero
// - Overflow when carry into/out of MSB differ
// - Status bits seven and six read zero
// - Only program counter pushed, no status save
// - Interrupt control at 0x0b, enables, zeros
// - Service clears global enable, pending still latch
// - Acknowledge only while stack not full
// - External pending set on pin falling edge
// - External service vectors 0x04, clears flags
// - Timer overflow pending, vector 0x08
// - Return-from-irq sets global enable, return keeps
// - Nesting allowed when software re-enables
// - Requests serviced on next phase two pulse
// - External wins over timer when simultaneous
// - Pending holds until serviced or cleared
// - Both sources wake the halted processor
// - Return stack has four levels
// - Already-pending flag before halt never wakes
package sfic_pkg;
    localparam logic [7:0] STATUS_ADDR = 8'h0a;
    localparam logic [7:0] INTCTL_ADDR = 8'h0b;
    localparam int CARRY_BIT = 0;
    localparam int HCARRY_BIT = 1;
    localparam int ZERO_BIT = 2;
    localparam int OVF_BIT = 3;
    localparam int PDOWN_BIT = 4;
    localparam int WDTO_BIT = 5;
    localparam int GIE_BIT = 0;
    localparam int EIE_BIT = 1;
    localparam int TIE_BIT = 2;
    localparam int EPEND_BIT = 4;
    localparam int TPEND_BIT = 5;
    localparam logic [7:0] STATUS_WMASK = 8'h0f;
    localparam logic [7:0] STATUS_RMASK = 8'h3f;
    localparam logic [7:0] INTCTL_RMASK = 8'h37;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] INTCTL_RESET = 8'h00;
    localparam logic [10:0] EXT_VECTOR = 11'h004;
    localparam logic [10:0] TMR_VECTOR = 11'h008;
    localparam int STACK_LEVELS = 4;
    typedef enum logic [2:0] {
        SFIC_ALU_NONE,
        SFIC_ALU_ADD,
        SFIC_ALU_SUB,
        SFIC_ALU_LOGIC,
        SFIC_ALU_ROTC
    } sfic_alu_op_t;
endpackage : sfic_pkg

// File: sfic_alu_flags.sv
// Flag computation for one ALU operation
module sfic_alu_flags
    import sfic_pkg::*;
(
    // Operation
    input wire sfic_alu_op_t op_i,
    input wire logic [7:0] a_i,
    input wire logic [7:0] b_i,
    input wire logic carry_in_i,
    input wire logic [7:0] result_i,
    input wire logic rot_carry_i,
    // Flags
    output logic update_o,
    output logic [3:0] flags_o
);
    wire logic [7:0] b_eff = (op_i == SFIC_ALU_SUB) ? ~b_i : b_i;
    wire logic [4:0] low_sum = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in_i};
    wire logic [7:0] low7_sum = {1'b0, a_i[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, carry_in_i};
    wire logic [8:0] full_sum = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, carry_in_i};
    wire logic arith = (op_i == SFIC_ALU_ADD) || (op_i == SFIC_ALU_SUB);
    // Subtract is a + ~b + carry, so carry out means no borrow
    wire logic carry_new = arith ? full_sum[8] : rot_carry_i;
    wire logic hcarry_new = low_sum[4];
    wire logic zero_new = (result_i == 8'h00);
    wire logic ovf_new = low7_sum[7] ^ full_sum[8];
    // Every op except none updates all four flags, logic ops and rotates included
    assign update_o = (op_i != SFIC_ALU_NONE);
    assign flags_o = {ovf_new, zero_new, hcarry_new, carry_new};
endmodule : sfic_alu_flags

// File: sfic_status_irq.sv
// Status flags and interrupt controller
module sfic_status_irq
    import sfic_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Data memory access
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    // ALU results
    input wire sfic_alu_op_t alu_op_i,
    input wire logic [7:0] alu_a_i,
    input wire logic [7:0] alu_b_i,
    input wire logic alu_cin_i,
    input wire logic [7:0] alu_result_i,
    input wire logic alu_rot_carry_i,
    // Core events
    input wire logic phase_two_pulse_i,
    input wire logic watchdog_clear_op_i,
    input wire logic halt_op_i,
    input wire logic watchdog_timeout_i,
    input wire logic return_op_i,
    input wire logic return_from_irq_op_i,
    input wire logic [2:0] stack_depth_i,
    input wire logic halted_i,
    // Interrupt sources
    input wire logic ext_irq_pin_i,
    input wire logic timer_overflow_i,
    // Interrupt answer
    output logic irq_ack_o,
    output logic [10:0] irq_vector_o,
    output logic wake_o
);
    logic [3:0] arith_flags;
    logic power_down_flag;
    logic watchdog_timeout_flag;
    logic global_irq_enable;
    logic ext_irq_enable;
    logic timer_irq_enable;
    logic ext_irq_pending;
    logic timer_irq_pending;
    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic ext_wake_block;
    logic tmr_wake_block;
    logic halted_prev;
    logic [10:0] vector_q;
    logic ack_q;
    logic alu_update;
    logic [3:0] alu_flags;

    sfic_alu_flags u_flags (
        .op_i(alu_op_i),
        .a_i(alu_a_i),
        .b_i(alu_b_i),
        .carry_in_i(alu_cin_i),
        .result_i(alu_result_i),
        .rot_carry_i(alu_rot_carry_i),
        .update_o(alu_update),
        .flags_o(alu_flags)
    );

    // Address decode
    wire logic status_sel = (addr_i == STATUS_ADDR);
    wire logic intctl_sel = (addr_i == INTCTL_ADDR);
    wire logic status_wr = wr_i && status_sel;
    wire logic intctl_wr = wr_i && intctl_sel;

    // Read views; upper bits and unused bits are absent
    wire logic [7:0] status_view = {2'b00, watchdog_timeout_flag, power_down_flag,
                                    arith_flags};
    wire logic [7:0] intctl_view = {2'b00, timer_irq_pending, ext_irq_pending, 1'b0,
                                    timer_irq_enable, ext_irq_enable,
                                    global_irq_enable};

    // Stack full gates every acknowledge; full means all four levels used
    wire logic stack_full = (stack_depth_i >= 3'(STACK_LEVELS));
    wire logic fall_edge = pin_prev && !pin_sync;
    wire logic ext_fire = global_irq_enable && ext_irq_enable && ext_irq_pending;
    wire logic tmr_fire = global_irq_enable && timer_irq_enable && timer_irq_pending;
    // Serviced only on the phase two pulse after the request latched
    wire logic take = phase_two_pulse_i && !stack_full && (ext_fire || tmr_fire);
    wire logic take_ext = take && ext_fire;
    wire logic take_tmr = take && !ext_fire;

    // Halt entry snapshots already-pending flags to disable their wake-up
    wire logic halt_entry = halted_i && !halted_prev;
    wire logic ext_wake = ext_irq_pending && !ext_wake_block;
    wire logic tmr_wake = timer_irq_pending && !tmr_wake_block;

    // Pin synchroniser; first stage feeds only the second
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end else begin
            pin_meta <= ext_irq_pin_i;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Arithmetic flags: ALU result has priority over a software write
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            arith_flags <= STATUS_RESET[3:0];
        end else if (alu_update) begin
            arith_flags <= alu_flags;
        end else if (status_wr) begin
            arith_flags <= wdata_i[3:0] & STATUS_WMASK[3:0];
        end
    end

    // Power-down and timeout ignore writes; only core events move them
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            power_down_flag <= STATUS_RESET[PDOWN_BIT];
            watchdog_timeout_flag <= STATUS_RESET[WDTO_BIT];
        end else begin
            if (watchdog_clear_op_i) begin
                power_down_flag <= 1'b0;
            end else if (halt_op_i) begin
                power_down_flag <= 1'b1;
            end
            // Timeout set wins so a timeout is never lost under a clear
            if (watchdog_timeout_i) begin
                watchdog_timeout_flag <= 1'b1;
            end else if (watchdog_clear_op_i || halt_op_i) begin
                watchdog_timeout_flag <= 1'b0;
            end
        end
    end

    // Enables: service clears global, return-from-irq sets it
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            global_irq_enable <= INTCTL_RESET[GIE_BIT];
            ext_irq_enable <= INTCTL_RESET[EIE_BIT];
            timer_irq_enable <= INTCTL_RESET[TIE_BIT];
        end else begin
            if (take) begin
                global_irq_enable <= 1'b0;
            end else if (return_from_irq_op_i) begin
                global_irq_enable <= 1'b1;
            end else if (intctl_wr) begin
                global_irq_enable <= wdata_i[GIE_BIT];
            end
            if (intctl_wr) begin
                ext_irq_enable <= wdata_i[EIE_BIT];
                timer_irq_enable <= wdata_i[TIE_BIT];
            end
        end
    end

    // Pending flags: hardware set beats service and software clear
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ext_irq_pending <= INTCTL_RESET[EPEND_BIT];
            timer_irq_pending <= INTCTL_RESET[TPEND_BIT];
        end else begin
            if (fall_edge) begin
                ext_irq_pending <= 1'b1;
            end else if (take_ext) begin
                ext_irq_pending <= 1'b0;
            end else if (intctl_wr) begin
                ext_irq_pending <= wdata_i[EPEND_BIT];
            end
            if (timer_overflow_i) begin
                timer_irq_pending <= 1'b1;
            end else if (take_tmr) begin
                timer_irq_pending <= 1'b0;
            end else if (intctl_wr) begin
                timer_irq_pending <= wdata_i[TPEND_BIT];
            end
        end
    end

    // Vector and acknowledge; the core pushes only its program counter
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            vector_q <= 11'h000;
        end else begin
            ack_q <= take;
            if (take_ext) begin
                vector_q <= EXT_VECTOR;
            end else if (take_tmr) begin
                vector_q <= TMR_VECTOR;
            end
        end
    end

    // Wake-up masking across halt entry
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            halted_prev <= 1'b0;
            ext_wake_block <= 1'b0;
            tmr_wake_block <= 1'b0;
        end else begin
            halted_prev <= halted_i;
            if (halt_entry) begin
                ext_wake_block <= ext_irq_pending;
                tmr_wake_block <= timer_irq_pending;
            end else if (!halted_i) begin
                ext_wake_block <= 1'b0;
                tmr_wake_block <= 1'b0;
            end
        end
    end

    // Read data is registered; unmapped addresses return zero
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (status_sel) begin
            rdata_o <= status_view & STATUS_RMASK;
        end else if (intctl_sel) begin
            rdata_o <= intctl_view & INTCTL_RMASK;
        end else begin
            rdata_o <= 8'h00;
        end
    end

    assign irq_ack_o = ack_q;
    assign irq_vector_o = vector_q;
    // Wake is a level; halted core leaves on either source
    assign wake_o = halted_i && halted_prev && (ext_wake || tmr_wake);

    sequence ack_seq;
        ##1 irq_ack_o && !global_irq_enable;
    endsequence

    ack_clears_a: assert property (@(posedge clock_i) disable iff (rst_i)
        take |-> ack_seq) else $error("service did not clear global enable");
    full_blocks_a: assert property (@(posedge clock_i) disable iff (rst_i)
        stack_full |-> ##1 !irq_ack_o) else $error("ack while stack full");
    ext_vec_a: assert property (@(posedge clock_i) disable iff (rst_i)
        take_ext |=> irq_vector_o == EXT_VECTOR) else $error("bad external vector");
    tmr_vec_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (take && !ext_fire) |=> irq_vector_o == TMR_VECTOR) else $error("bad timer vector");
    edge_pend_a: assert property (@(posedge clock_i) disable iff (rst_i)
        fall_edge |=> ext_irq_pending) else $error("falling edge lost");
    return_from_irq_op_gie_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (return_from_irq_op_i && !take) |=> global_irq_enable) else $error("return_from_irq_op no enable");
    ret_keep_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (return_op_i && !return_from_irq_op_i && !take && !intctl_wr)
        |=> $stable(global_irq_enable)) else $error("ret changed enable");
    pd_protect_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (!halt_op_i && !watchdog_clear_op_i) |=> $stable(power_down_flag))
        else $error("power-down changed");
    to_protect_a: assert property (@(posedge clock_i) disable iff (rst_i)
        (!halt_op_i && !watchdog_clear_op_i && !watchdog_timeout_i)
        |=> $stable(watchdog_timeout_flag)) else $error("timeout changed");
    upper_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
        $past(status_sel) |-> rdata_o[7:6] == 2'b00) else $error("upper status bits");
    only_t2_a: assert property (@(posedge clock_i) disable iff (rst_i)
        irq_ack_o |-> $past(phase_two_pulse_i)) else $error("ack off phase two");
endmodule : sfic_status_irq

// File: sfic_core_model.sv
// Core side: instruction phase timing and return stack level
module sfic_core_model (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Core events
    input wire logic irq_ack_i,
    input wire logic call_i,
    input wire logic return_i,
    // Pipeline state
    output logic phase_two_pulse_o,
    output logic [2:0] stack_depth_o
);
    logic [1:0] phase;

    // Four clocks per instruction cycle, one service instant each
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end
    assign phase_two_pulse_o = (phase == 2'h1);

    // A push on a full stack drops the oldest entry, so the level saturates
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stack_depth_o <= 3'h0;
        end else if ((irq_ack_i | call_i) && stack_depth_o < 3'h4) begin
            stack_depth_o <= stack_depth_o + 3'h1;
        end else if (return_i && stack_depth_o != 3'h0) begin
            stack_depth_o <= stack_depth_o - 3'h1;
        end
    end
endmodule : sfic_core_model

// File: status_flags_and_interrupt_control_test.sv
// Register, flag and interrupt sequence checks
module status_flags_and_interrupt_control_test;
    import sfic_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i, rst_i, wr, pin, tovf, halted, ack, wake, p2;
    logic [7:0] addr, wdata, rdata, a, b, res;
    logic cin;
    logic [5:0] ev;
    logic [2:0] depth;
    logic [10:0] vec;
    sfic_alu_op_t op;
    int miscompares = 0;
    int n_tests = 0;
    int n_ack = 0;

    sfic_status_irq dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wr_i(wr),
        .wdata_i(wdata), .rdata_o(rdata), .alu_op_i(op), .alu_a_i(a), .alu_b_i(b),
        .alu_cin_i(cin), .alu_result_i(res), .alu_rot_carry_i(1'b0),
        .phase_two_pulse_i(p2), .watchdog_clear_op_i(ev[0]), .halt_op_i(ev[1]),
        .watchdog_timeout_i(ev[2]), .return_op_i(ev[3]), .return_from_irq_op_i(ev[4]),
        .stack_depth_i(depth), .halted_i(halted), .ext_irq_pin_i(pin),
        .timer_overflow_i(tovf), .irq_ack_o(ack), .irq_vector_o(vec), .wake_o(wake));
    sfic_core_model core (.clock_i(clock_i), .rst_i(rst_i), .irq_ack_i(ack),
        .call_i(ev[5]), .return_i(ev[3] | ev[4]), .phase_two_pulse_o(p2),
        .stack_depth_o(depth));

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    // Acknowledge count lets a blocked service show as no change
    always @(posedge clock_i) begin
        if (ack === 1'b1) n_ack++;
    end

    task chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task wr8(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clock_i);
        addr <= ad;
        wr <= 1'b1;
        wdata <= d;
        @(posedge clock_i);
        wr <= 1'b0;
    endtask : wr8
    task rd(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clock_i);
        addr <= ad;
        repeat (2) @(posedge clock_i);
        #1 chk("rdata", {3'h0, exp}, {3'h0, rdata});
    endtask : rd
    task alu(input sfic_alu_op_t o, input logic [7:0] x, y, input logic c, input logic [7:0] r);
        @(posedge clock_i);
        op <= o;
        a <= x;
        b <= y;
        cin <= c;
        res <= r;
        @(posedge clock_i);
        op <= SFIC_ALU_NONE;
    endtask : alu
    // Event bits: clear, halt, timeout, return, irq return, call
    task pulse(input logic [5:0] m);
        @(posedge clock_i);
        ev <= m;
        @(posedge clock_i);
        ev <= 6'h00;
    endtask : pulse
    // Bounded wait: a service instant comes every four clocks
    task wait_ack(input logic [10:0] v);
        int i;
        i = 0;
        while (ack !== 1'b1 && i < 24) begin
            @(posedge clock_i);
            #1 i++;
        end
        chk("irq_ack", 11'h001, {10'h0, ack});
        chk("irq_vector", v, vec);
    endtask : wait_ack
    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #400000;
        miscompares++;
        end_of_test;
    end

    initial begin
        {rst_i, pin} = 2'b11;
        {wr, tovf, halted, cin} = 4'h0;
        {addr, wdata, a, b, res} = 40'h0;
        ev = 6'h00;
        op = SFIC_ALU_NONE;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        rd(STATUS_ADDR, STATUS_RESET);
        rd(INTCTL_ADDR, INTCTL_RESET);
        rd(8'h0c, 8'h00);
        wr8(STATUS_ADDR, 8'hff);
        rd(STATUS_ADDR, 8'h0f);
        alu(SFIC_ALU_ADD, 8'h0f, 8'h01, 1'b0, 8'h10);
        rd(STATUS_ADDR, 8'h02);
        alu(SFIC_ALU_ADD, 8'h80, 8'h80, 1'b0, 8'h00);
        rd(STATUS_ADDR, 8'h0d);
        alu(SFIC_ALU_SUB, 8'h05, 8'h03, 1'b1, 8'h02);
        rd(STATUS_ADDR, 8'h03);
        pulse(6'h02);
        rd(STATUS_ADDR, 8'h13);
        pulse(6'h04);
        rd(STATUS_ADDR, 8'h33);
        wr8(STATUS_ADDR, 8'h00);
        rd(STATUS_ADDR, 8'h30);
        pulse(6'h01);
        rd(STATUS_ADDR, 8'h00);
        // Global enable stays off so both software-set requests stay pending
        wr8(INTCTL_ADDR, 8'hfe);
        rd(INTCTL_ADDR, 8'h36);
        wr8(INTCTL_ADDR, 8'h03);
        pin <= 1'b0;
        wait_ack(EXT_VECTOR);
        pin <= 1'b1;
        rd(INTCTL_ADDR, 8'h02);
        @(posedge clock_i);
        tovf <= 1'b1;
        @(posedge clock_i);
        tovf <= 1'b0;
        rd(INTCTL_ADDR, 8'h22);
        wr8(INTCTL_ADDR, 8'h26);
        pulse(6'h10);
        wait_ack(TMR_VECTOR);
        wr8(INTCTL_ADDR, 8'h37);
        wait_ack(EXT_VECTOR);
        pulse(6'h08);
        rd(INTCTL_ADDR, 8'h26);
        wr8(INTCTL_ADDR, 8'h27);
        wait_ack(TMR_VECTOR);
        pulse(6'h20);
        pulse(6'h20);
        wr8(INTCTL_ADDR, 8'h13);
        n_ack = 0;
        repeat (12) @(posedge clock_i);
        chk("acks_when_full", 11'h000, n_ack[10:0]);
        pulse(6'h08);
        wait_ack(EXT_VECTOR);
        wr8(INTCTL_ADDR, 8'h02);
        halted <= 1'b1;
        repeat (3) @(posedge clock_i);
        pin <= 1'b0;
        repeat (6) @(posedge clock_i);
        #1 chk("wake", 11'h001, {10'h0, wake});
        halted <= 1'b0;
        end_of_test;
    end
endmodule : status_flags_and_interrupt_control_test
